// *** design/tccd_top.sv ***
/*
 type-c cc attach detect: source decode, sink and dual-role, fast role
 swap, dead battery hand-over and boot-config capture, apb registers.
 assumes analog comparators give synchronous flags per cc line and the
 adc result arrives with a valid strobe once after power-up.
*/
// Function
// - source with both lines open: nothing attached, watch both, no power
// - one rd, one open: sink attached, vbus on, watch rd line only
// - one ra, one open: powered cable, no power, watch both lines
// - ra plus rd: vbus and vconn on ra line, watch rd line only
// - rd on both is debug, ra on both audio; either detaches
// - source drives pull-up, sink seen below sink-detect threshold
// - advertisement selectable default 500/900 ma, 1.5 a, 3 a
// - below cable threshold classifies line as powered cable vconn input
// - disconnection when monitored line rises above sink-detect threshold
// - sink presents pull-down on both lines, waits for source
// - sink attach indicated by vbus presence, not cc voltage
// - sink derives source current from applied pull-up level
// - dual-role alternates lines between pull-down and pull-up
// - sink with swap enabled: low cc flags core, becomes source
// - source with swap: core enables swap pull-down, becomes sink
// - dead battery untrimmed pull-down until software selects trimmed one
// - power-up adc code of bus-power input chooses start-up behaviour
// - wait-external boot drives sink path only on designated pin
// - adc result kept internal except its top three bits, readable in the boot register over apb
`timescale 1ns/1ns
`default_nettype none
`include "tccd_cfg.svh"
module tccd_top #(
   parameter int DW = 16,
   parameter int ADCW = 8,
   parameter logic [15:0] DRP_HALF = `TCCD_DRP_HALF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] cc_below_sink_detect,
   input wire logic [1:0] cc_below_cable_detect,
   input wire logic [1:0] cc_above_vrd,
   input wire logic [1:0] cc_src_level_1p5,
   input wire logic [1:0] cc_src_level_3p0,
   input wire logic [1:0] cc_below_role_swap,
   input wire logic vbus_present,
   input wire logic dead_battery,
   input wire logic adc_valid,
   input wire logic [ADCW-1:0] adc_code,
   output logic [1:0] source_pullup_current,
   output logic [1:0] source_pullup_en,
   output logic [1:0] trimmed_sink_pulldown,
   output logic [1:0] dead_battery_pulldown,
   output logic [1:0] role_swap_pulldown,
   output logic vbus_source_en,
   output logic vconn_en_cc1,
   output logic vconn_en_cc2,
   output logic external_sink_path_pin
);
   logic [31:0] ctrl_q;
   logic [DW-1:0] deb_q;
   logic [2:0] evt_q;
   logic [2:0] boot_q;
   logic boot_done_q;
   logic db_active_q;
   logic drp_src_q;
   logic [15:0] drp_cnt_q;
   logic frs_role_q;
   logic swap_to_src_q;
   logic swap_to_snk_q;
   tccd_pkg::tccd_state_t st_q;
   tccd_pkg::tccd_state_t st_d;
   tccd_pkg::tccd_term_t raw1;
   tccd_pkg::tccd_term_t raw2;
   tccd_pkg::tccd_term_t t1;
   tccd_pkg::tccd_term_t t2;
   tccd_pkg::tccd_role_t role;
   logic sourcing;
   logic wr;
   logic rd;
   logic addr_ok;
   logic [2:0] evt_set;
   logic [1:0] adv_cap;
   logic connected;
   logic swap_detect;

   // swap latches override the programmed role until the role field changes
   assign role = tccd_pkg::tccd_role_t'(
      ctrl_q[`TCCD_CTRL_ROLE_HI:`TCCD_CTRL_ROLE_LO]);
   always_comb
   begin
      unique case (role)
         tccd_pkg::TCCD_ROLE_SRC: sourcing = !swap_to_snk_q;
         tccd_pkg::TCCD_ROLE_SNK: sourcing = swap_to_src_q;
         tccd_pkg::TCCD_ROLE_DRP: sourcing = drp_src_q;
         tccd_pkg::TCCD_ROLE_OFF: sourcing = 1'b0;
      endcase
   end

   tccd_term_decode u_dec1 (
      .sourcing(sourcing),
      .below_sink_detect(cc_below_sink_detect[0]),
      .below_cable_detect(cc_below_cable_detect[0]),
      .above_sink_vrd(cc_above_vrd[0]),
      .term(raw1)
   );
   tccd_term_decode u_dec2 (
      .sourcing(sourcing),
      .below_sink_detect(cc_below_sink_detect[1]),
      .below_cable_detect(cc_below_cable_detect[1]),
      .above_sink_vrd(cc_above_vrd[1]),
      .term(raw2)
   );
   tccd_debounce #(.CW(DW)) u_deb1 (
      .pclk(pclk),
      .presetn(presetn),
      .ce(clk_en),
      .stable_cycles(deb_q),
      .term_raw(raw1),
      .term_stable(t1)
   );
   tccd_debounce #(.CW(DW)) u_deb2 (
      .pclk(pclk),
      .presetn(presetn),
      .ce(clk_en),
      .stable_cycles(deb_q),
      .term_raw(raw2),
      .term_stable(t2)
   );

   // source decode table; watched lines follow from which terms matter
   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         tccd_pkg::TCCD_ST_IDLE, tccd_pkg::TCCD_ST_CABLE:
         begin
            if (!sourcing)
               st_d = tccd_pkg::TCCD_ST_SINK;
            else if (t1 == tccd_pkg::TCCD_RD && t2 == tccd_pkg::TCCD_RD)
               st_d = tccd_pkg::TCCD_ST_DEBUG;
            else if (t1 == tccd_pkg::TCCD_RA && t2 == tccd_pkg::TCCD_RA)
               st_d = tccd_pkg::TCCD_ST_AUDIO;
            else if ((t1 == tccd_pkg::TCCD_RA && t2 == tccd_pkg::TCCD_RD) ||
                     (t1 == tccd_pkg::TCCD_RD && t2 == tccd_pkg::TCCD_RA))
               st_d = tccd_pkg::TCCD_ST_CBL_SNK;
            else if (t1 == tccd_pkg::TCCD_RD || t2 == tccd_pkg::TCCD_RD)
               st_d = tccd_pkg::TCCD_ST_SNK_ATT;
            else if (t1 == tccd_pkg::TCCD_RA || t2 == tccd_pkg::TCCD_RA)
               st_d = tccd_pkg::TCCD_ST_CABLE;
            else
               st_d = tccd_pkg::TCCD_ST_IDLE;
         end
         tccd_pkg::TCCD_ST_SNK_ATT, tccd_pkg::TCCD_ST_CBL_SNK:
         begin
            // only the rd line ends the session; ra line ignored
            if (!sourcing || (t1 != tccd_pkg::TCCD_RD &&
                t2 != tccd_pkg::TCCD_RD))
               st_d = tccd_pkg::TCCD_ST_IDLE;
         end
         tccd_pkg::TCCD_ST_DEBUG:
         begin
            if (!sourcing || t1 != tccd_pkg::TCCD_RD ||
                t2 != tccd_pkg::TCCD_RD)
               st_d = tccd_pkg::TCCD_ST_IDLE;
         end
         tccd_pkg::TCCD_ST_AUDIO:
         begin
            if (!sourcing || t1 != tccd_pkg::TCCD_RA ||
                t2 != tccd_pkg::TCCD_RA)
               st_d = tccd_pkg::TCCD_ST_IDLE;
         end
         tccd_pkg::TCCD_ST_SINK:
         begin
            if (sourcing)
               st_d = tccd_pkg::TCCD_ST_IDLE;
            else if (vbus_present)
               st_d = tccd_pkg::TCCD_ST_SINK_ATT;
         end
         tccd_pkg::TCCD_ST_SINK_ATT:
         begin
            if (sourcing)
               st_d = tccd_pkg::TCCD_ST_IDLE;
            else if (!vbus_present)
               st_d = tccd_pkg::TCCD_ST_SINK;
         end
         default: st_d = tccd_pkg::TCCD_ST_IDLE;
      endcase
   end

   // connection state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_q <= tccd_pkg::TCCD_ST_IDLE;
      else if (clk_en)
         st_q <= st_d;
   end

   assign connected = st_q != tccd_pkg::TCCD_ST_IDLE &&
      st_q != tccd_pkg::TCCD_ST_SINK && st_q != tccd_pkg::TCCD_ST_CABLE;

   // dual-role toggle halts once connected; a cable alone keeps it toggling
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         drp_cnt_q <= '0;
         drp_src_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (role != tccd_pkg::TCCD_ROLE_DRP || connected)
            drp_cnt_q <= '0;
         else if (drp_cnt_q >= DRP_HALF)
         begin
            drp_cnt_q <= '0;
            drp_src_q <= !drp_src_q;
         end
         else
            drp_cnt_q <= drp_cnt_q + 16'h0001;
      end
   end

   // fast role swap latches; each cleared when the role field no longer selects its role
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         swap_to_src_q <= 1'b0;
         swap_to_snk_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (swap_detect)
            swap_to_src_q <= 1'b1;
         else if (role != tccd_pkg::TCCD_ROLE_SNK)
            swap_to_src_q <= 1'b0;
         if (ctrl_q[`TCCD_CTRL_FRS_EN] && ctrl_q[`TCCD_CTRL_FRS_SIG] &&
             sourcing && connected)
            swap_to_snk_q <= 1'b1;
         else if (role != tccd_pkg::TCCD_ROLE_SRC)
            swap_to_snk_q <= 1'b0;
      end
   end
   assign frs_role_q = swap_to_src_q | swap_to_snk_q;

   // boot capture: adc code read once, only the decoded choice kept
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         boot_q <= 3'h0;
         boot_done_q <= 1'b0;
         db_active_q <= 1'b1; // untrimmed pull-down from reset; boot capture keeps it only on dead battery
      end
      else if (clk_en)
      begin
         if (adc_valid && !boot_done_q)
         begin
            boot_q <= adc_code[ADCW-1:ADCW-3];
            boot_done_q <= 1'b1;
            db_active_q <= dead_battery;
         end
         else if (ctrl_q[`TCCD_CTRL_DB_REL])
            db_active_q <= 1'b0;
      end
   end

   // swap flagged in the one cycle before the source latch takes over
   assign swap_detect = ctrl_q[`TCCD_CTRL_FRS_EN] && !sourcing &&
      st_q == tccd_pkg::TCCD_ST_SINK_ATT && |cc_below_role_swap &&
      !swap_to_src_q;
   // event sticky bits; a new event wins over a clear in the same cycle
   assign evt_set = {swap_detect,
      st_q != st_d && st_d == tccd_pkg::TCCD_ST_IDLE,
      st_q != st_d && st_q == tccd_pkg::TCCD_ST_IDLE};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         evt_q <= 3'h0;
      else if (clk_en)
      begin
         if (wr && paddr == `TCCD_OFF_EVT)
            evt_q <= (evt_q & ~pwdata[2:0]) | evt_set;
         else
            evt_q <= evt_q | evt_set;
      end
   end

   // apb slave, zero wait states
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite && clk_en;
   assign rd = psel && !pwrite && clk_en; // frozen reads keep old data
   assign addr_ok = paddr == `TCCD_OFF_CTRL || paddr == `TCCD_OFF_DEB ||
      paddr == `TCCD_OFF_STAT || paddr == `TCCD_OFF_EVT ||
      paddr == `TCCD_OFF_BOOT;
   assign pslverr = psel && penable && !addr_ok;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= `TCCD_CTRL_RST;
         deb_q <= DW'(`TCCD_DEB_RST);
      end
      else if (wr && paddr == `TCCD_OFF_CTRL)
         ctrl_q <= pwdata;
      else if (wr && paddr == `TCCD_OFF_DEB)
         deb_q <= pwdata[DW-1:0];
   end

   // read mux registered in setup so data is stable in access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd && !penable)
      begin
         unique case (paddr)
            `TCCD_OFF_CTRL: prdata <= ctrl_q;
            `TCCD_OFF_DEB: prdata <= 32'(deb_q);
            `TCCD_OFF_STAT: prdata <= {18'h0_0000, adv_cap, t2, t1,
               2'(frs_role_q), db_active_q, sourcing, st_q};
            `TCCD_OFF_EVT: prdata <= {29'h0, evt_q};
            `TCCD_OFF_BOOT: prdata <= {28'h0, boot_done_q, boot_q};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // sink side: advertised current from the pull-up level seen
   assign adv_cap = (|cc_src_level_3p0) ? 2'h3 :
      (|cc_src_level_1p5) ? 2'h2 : 2'h1;

   // pin and power drive
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         source_pullup_current <= 2'h0;
         source_pullup_en <= 2'h0;
         trimmed_sink_pulldown <= 2'h0;
         dead_battery_pulldown <= 2'h3;
         role_swap_pulldown <= 2'h0;
         vbus_source_en <= 1'b0;
         vconn_en_cc1 <= 1'b0;
         vconn_en_cc2 <= 1'b0;
         external_sink_path_pin <= 1'b0;
      end
      else if (clk_en)
      begin
         source_pullup_current <=
            ctrl_q[`TCCD_CTRL_ADV_HI:`TCCD_CTRL_ADV_LO];
         source_pullup_en <= {2{sourcing}};
         dead_battery_pulldown <= {2{db_active_q}};
         trimmed_sink_pulldown <= {2{!sourcing && !db_active_q}};
         role_swap_pulldown <= {t2 != tccd_pkg::TCCD_OPEN,
            t1 != tccd_pkg::TCCD_OPEN} & {2{swap_to_snk_q}};
         vbus_source_en <= sourcing &&
            (st_q == tccd_pkg::TCCD_ST_SNK_ATT ||
             st_q == tccd_pkg::TCCD_ST_CBL_SNK);
         vconn_en_cc1 <= sourcing && st_q == tccd_pkg::TCCD_ST_CBL_SNK &&
            t1 == tccd_pkg::TCCD_RA;
         vconn_en_cc2 <= sourcing && st_q == tccd_pkg::TCCD_ST_CBL_SNK &&
            t2 == tccd_pkg::TCCD_RA;
         external_sink_path_pin <= boot_q == `TCCD_BOOT_WAIT_EXT &&
            boot_done_q && st_q == tccd_pkg::TCCD_ST_SINK_ATT;
      end
   end

   // no power with nothing attached
   AST_IDLE_NO_POWER: assert property (@(posedge pclk) disable iff
      (!presetn) $past(st_q) == tccd_pkg::TCCD_ST_IDLE && $past(clk_en)
      |-> !vbus_source_en && !vconn_en_cc1 && !vconn_en_cc2)
      else $error("power while idle");
   // sink attach powers vbus without vconn next cycle
   AST_SNK_VBUS: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == tccd_pkg::TCCD_ST_SNK_ATT && sourcing && clk_en
      |=> vbus_source_en && !vconn_en_cc1 && !vconn_en_cc2)
      else $error("sink attach power wrong");
   AST_CABLE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == tccd_pkg::TCCD_ST_CABLE && clk_en |=> !vbus_source_en)
      else $error("cable only powered vbus");
   AST_VCONN_ONE: assert property (@(posedge pclk) disable iff (!presetn)
      !(vconn_en_cc1 && vconn_en_cc2))
      else $error("vconn on both lines");
   AST_ACC_DETACH: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == tccd_pkg::TCCD_ST_DEBUG && clk_en && t1 == tccd_pkg::TCCD_OPEN
      |=> st_q == tccd_pkg::TCCD_ST_IDLE)
      else $error("debug detach missed");
   AST_SINK_VBUS: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == tccd_pkg::TCCD_ST_SINK && !sourcing && vbus_present && clk_en
      |=> st_q == tccd_pkg::TCCD_ST_SINK_ATT)
      else $error("sink attach on vbus missed");
   AST_DB_PULLDOWN: assert property (@(posedge pclk) disable iff (!presetn)
      !(dead_battery_pulldown[0] && trimmed_sink_pulldown[0]))
      else $error("both pull-downs on");
   AST_EXT_PATH: assert property (@(posedge pclk) disable iff (!presetn)
      external_sink_path_pin |-> boot_q == `TCCD_BOOT_WAIT_EXT)
      else $error("external path without boot choice");
endmodule : tccd_top
`default_nettype wire

// *** design/tccd_cfg.svh ***
/*
 constants for the type-c cc attach detect block: register offsets,
 field positions, reset values and timing counts.
 assumes inclusion by bare name from design and bench files.
*/
`ifndef TCCD_CFG_SVH
`define TCCD_CFG_SVH

// register byte offsets on apb
`define TCCD_OFF_CTRL 12'h000
`define TCCD_OFF_DEB 12'h004
`define TCCD_OFF_STAT 12'h008
`define TCCD_OFF_EVT 12'h00C
`define TCCD_OFF_BOOT 12'h010

// control field positions
`define TCCD_CTRL_ROLE_LO 0
`define TCCD_CTRL_ROLE_HI 1
`define TCCD_CTRL_ADV_LO 2
`define TCCD_CTRL_ADV_HI 3
`define TCCD_CTRL_FRS_EN 4
`define TCCD_CTRL_FRS_SIG 5
`define TCCD_CTRL_DB_REL 6
`define TCCD_CTRL_PORT_EN 7

// event bits
`define TCCD_EVT_ATTACH 0
`define TCCD_EVT_DETACH 1
`define TCCD_EVT_FRS 2

// reset values and dual-role toggle half-period count
`define TCCD_CTRL_RST 32'h0000_0000
`define TCCD_DEB_RST 16'h00C8
`define TCCD_DRP_HALF 16'h1388

// boot code meaning wait-for-external-supply
`define TCCD_BOOT_WAIT_EXT 3'h5

`endif

// *** design/tccd_pkg.sv ***
/*
 types for the type-c cc attach detect block.
 assumes nothing beyond the cfg header.
*/
package tccd_pkg;
   // decoded termination seen on one cc line
   typedef enum logic [1:0] {TCCD_OPEN, TCCD_RD, TCCD_RA, TCCD_RP} tccd_term_t;
   // advertised source current
   typedef enum logic [1:0] {TCCD_ADV_DEF5, TCCD_ADV_DEF9, TCCD_ADV_1P5,
      TCCD_ADV_3P0} tccd_adv_t;
   // port role selection
   typedef enum logic [1:0] {TCCD_ROLE_SRC, TCCD_ROLE_SNK, TCCD_ROLE_DRP,
      TCCD_ROLE_OFF} tccd_role_t;
   // connection state
   typedef enum logic [3:0] {TCCD_ST_IDLE, TCCD_ST_SNK_ATT, TCCD_ST_CABLE,
      TCCD_ST_CBL_SNK, TCCD_ST_DEBUG, TCCD_ST_AUDIO, TCCD_ST_SINK,
      TCCD_ST_SINK_ATT} tccd_state_t;
endpackage : tccd_pkg

// *** design/tccd_debounce.sv ***
/*
 debounce of one decoded cc line termination.
 assumes term_raw is synchronous to pclk and changes slowly.
*/
`timescale 1ns/1ns
`default_nettype none
module tccd_debounce #(
   parameter int CW = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [CW-1:0] stable_cycles,
   input wire tccd_pkg::tccd_term_t term_raw,
   output tccd_pkg::tccd_term_t term_stable
);
   tccd_pkg::tccd_term_t last_q;
   logic [CW-1:0] cnt_q;

   // output only moves after raw held for the programmed interval
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         last_q <= tccd_pkg::TCCD_OPEN;
         cnt_q <= '0;
         term_stable <= tccd_pkg::TCCD_OPEN;
      end
      else if (ce)
      begin
         if (term_raw != last_q)
         begin
            last_q <= term_raw;
            cnt_q <= '0;
         end
         else if (cnt_q >= stable_cycles)
            term_stable <= last_q;
         else
            cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule : tccd_debounce
`default_nettype wire

// *** design/tccd_term_decode.sv ***
/*
 classifies one cc line from comparator flags into a termination.
 assumes comparator thresholds are already set for the advertisement.
*/
`timescale 1ns/1ns
`default_nettype none
module tccd_term_decode (
   input wire logic sourcing,
   input wire logic below_sink_detect,
   input wire logic below_cable_detect,
   input wire logic above_sink_vrd,
   output tccd_pkg::tccd_term_t term
);
   // ra pulls lower than rd, so test the cable threshold first
   always_comb
   begin
      if (sourcing)
      begin
         if (below_cable_detect)
            term = tccd_pkg::TCCD_RA;
         else if (below_sink_detect)
            term = tccd_pkg::TCCD_RD;
         else
            term = tccd_pkg::TCCD_OPEN;
      end
      else
         term = above_sink_vrd ? tccd_pkg::TCCD_RP : tccd_pkg::TCCD_OPEN;
   end
endmodule : tccd_term_decode
`default_nettype wire

// *** dv/tccd_partner.sv ***
/*
 port partner model: turns the termination chosen on each cc line into
 the comparator flags the block sees. assumes the bench picks terms.
*/
`timescale 1ns/1ns
`default_nettype none
module tccd_partner (
   input wire tccd_pkg::tccd_term_t term_one,
   input wire tccd_pkg::tccd_term_t term_two,
   input wire logic [1:0] src_level,
   input wire logic [1:0] swap_drop,
   output logic [1:0] cc_below_sink_detect,
   output logic [1:0] cc_below_cable_detect,
   output logic [1:0] cc_above_vrd,
   output logic [1:0] cc_src_level_1p5,
   output logic [1:0] cc_src_level_3p0,
   output logic [1:0] cc_below_role_swap
);
   tccd_pkg::tccd_term_t t [2];
   assign t[0] = term_one;
   assign t[1] = term_two;
   // an open line trips nothing, ra trips both source thresholds
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         cc_below_sink_detect[i] = t[i] inside {tccd_pkg::TCCD_RD,
            tccd_pkg::TCCD_RA};
         cc_below_cable_detect[i] = t[i] == tccd_pkg::TCCD_RA;
         cc_above_vrd[i] = t[i] == tccd_pkg::TCCD_RP;
         cc_src_level_1p5[i] = cc_above_vrd[i] && src_level != 2'h0;
         cc_src_level_3p0[i] = cc_above_vrd[i] && src_level == 2'h2;
         cc_below_role_swap[i] = swap_drop[i];
      end
   end
endmodule : tccd_partner
`default_nettype wire

// *** dv/typec_cc_attach_detect_tb.sv ***
/*
 bench for the cc attach detect block: apb master, partner model and a
 behavioural source-decode model. assumes design files compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tccd_cfg.svh"
module typec_cc_attach_detect_tb;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] cc_below_sink_detect, cc_below_cable_detect, cc_above_vrd;
   logic [1:0] cc_src_level_1p5, cc_src_level_3p0, cc_below_role_swap;
   logic [1:0] source_pullup_current, source_pullup_en, role_swap_pulldown;
   logic [1:0] trimmed_sink_pulldown, dead_battery_pulldown, lvl, swp, prev;
   logic vbus_present, dead_battery, adc_valid, vbus_source_en, err;
   logic vconn_en_cc1, vconn_en_cc2, external_sink_path_pin;
   logic [7:0] adc_code;
   logic [6:0] e;
   tccd_pkg::tccd_term_t t1, t2;
   integer fail_count, tests_run, seed, n;

   tccd_top #(.DRP_HALF(16'h0014)) i_dut (.pclk, .presetn, .clk_en, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .cc_below_sink_detect, .cc_below_cable_detect, .cc_above_vrd,
      .cc_src_level_1p5, .cc_src_level_3p0, .cc_below_role_swap,
      .vbus_present, .dead_battery, .adc_valid, .adc_code,
      .source_pullup_current, .source_pullup_en, .trimmed_sink_pulldown,
      .dead_battery_pulldown, .role_swap_pulldown, .vbus_source_en,
      .vconn_en_cc1, .vconn_en_cc2, .external_sink_path_pin);
   tccd_partner i_partner (.term_one(t1), .term_two(t2), .src_level(lvl),
      .swap_drop(swp), .cc_below_sink_detect, .cc_below_cable_detect,
      .cc_above_vrd, .cc_src_level_1p5, .cc_src_level_3p0,
      .cc_below_role_swap);

   // free-running bench clock, 100 mhz
   always #5 pclk = ~pclk;

   task automatic chk(input string nm, input logic [31:0] got,
      input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input string nm, input logic [11:0] a,
      input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rd & m, exp);
   endtask : rchk

   // waits k clock edges, then lets registered outputs settle
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
      #1;
   endtask : cyc

   // source-side decode model: {vconn2, vconn1, vbus, state}
   function automatic logic [6:0] exp_src(input tccd_pkg::tccd_term_t a,
      input tccd_pkg::tccd_term_t b);
      int nrd;
      int nra;
      nrd = (a == tccd_pkg::TCCD_RD) + (b == tccd_pkg::TCCD_RD);
      nra = (a == tccd_pkg::TCCD_RA) + (b == tccd_pkg::TCCD_RA);
      if (nrd == 2)
         return 7'h04;
      if (nra == 2)
         return 7'h05;
      if (nrd == 1 && nra == 1)
         return {b == tccd_pkg::TCCD_RA, a == tccd_pkg::TCCD_RA, 5'h13};
      if (nrd == 1)
         return 7'h11;
      if (nra == 1)
         return 7'h02;
      return 7'h00;
   endfunction : exp_src

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   // watchdog well beyond the expected run of under a thousand cycles
   initial
   begin
      #300000;
      fail_count++;
      complete_run();
   end

   initial
   begin
      seed = 32'hB53B79BB;
      fail_count = 0;
      tests_run = 0;
      pclk = 1'b0;
      presetn = 1'b0;
      clk_en = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {lvl, swp, vbus_present, adc_valid, adc_code} = '0;
      t1 = tccd_pkg::TCCD_OPEN;
      t2 = tccd_pkg::TCCD_OPEN;
      dead_battery = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      cyc(1);
      chk("power_rst", {vbus_source_en, vconn_en_cc1, vconn_en_cc2}, 32'h0);
      rchk("ctrl_rst", `TCCD_OFF_CTRL, 32'hFF, 32'h0);
      rchk("deb_rst", `TCCD_OFF_DEB, 32'hFFFF, 32'hC8);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped_err", err, 32'h1);
      chk("unmapped_rd", rd, 32'h0);
      // boot code in the top adc bits, low bits random and hidden
      @(posedge pclk);
      adc_code <= {3'h5, 5'($random(seed))};
      adc_valid <= 1'b1;
      @(posedge pclk);
      adc_valid <= 1'b0;
      rchk("boot", `TCCD_OFF_BOOT, 32'hFFFF_FFFF, 32'hD);
      // pull-down stays untrimmed until software hands over
      dead_battery <= 1'b0;
      cyc(3);
      chk("db_hold", dead_battery_pulldown, 32'h3);
      apb(1'b1, `TCCD_OFF_CTRL, 32'h40);
      cyc(3);
      chk("db_off", dead_battery_pulldown, 32'h0);
      apb(1'b1, `TCCD_OFF_DEB, 32'h2);
      // a write while the clock enable is low must be lost
      clk_en <= 1'b0;
      apb(1'b1, `TCCD_OFF_DEB, 32'h7);
      clk_en <= 1'b1;
      rchk("deb_frozen", `TCCD_OFF_DEB, 32'hFFFF, 32'h2);
      for (int i = 0; i < 3; i++)
         for (int j = 0; j < 3; j++)
         begin
            n = $random(seed) & 3;
            apb(1'b1, `TCCD_OFF_CTRL, 32'hC0 | 32'(n << 2));
            cyc(2);
            chk("pullup", source_pullup_en, 32'h3);
            chk("adv", source_pullup_current, 32'(n));
            t1 <= tccd_pkg::tccd_term_t'(i);
            t2 <= tccd_pkg::tccd_term_t'(j);
            cyc(12);
            e = exp_src(tccd_pkg::tccd_term_t'(i), tccd_pkg::tccd_term_t'(j));
            chk("power", {vconn_en_cc2, vconn_en_cc1, vbus_source_en}, e[6:4]);
            rchk("state", `TCCD_OFF_STAT, 32'hF, e[3:0]);
            t1 <= tccd_pkg::TCCD_OPEN;
            t2 <= tccd_pkg::TCCD_OPEN;
            cyc(12);
            chk("detach", {vbus_source_en, vconn_en_cc1, vconn_en_cc2}, 32'h0);
            rchk("idle", `TCCD_OFF_STAT, 32'hF, 32'h0);
         end
      apb(1'b1, `TCCD_OFF_EVT, 32'h7);
      t1 <= tccd_pkg::TCCD_RD;
      cyc(12);
      rchk("evt_att", `TCCD_OFF_EVT, 32'h7, 32'h1);
      apb(1'b1, `TCCD_OFF_EVT, 32'h1);
      rchk("evt_clr", `TCCD_OFF_EVT, 32'h7, 32'h0);
      t1 <= tccd_pkg::TCCD_OPEN;
      cyc(12);
      rchk("evt_det", `TCCD_OFF_EVT, 32'h7, 32'h2);
      // cable line leaving must not end a cable-plus-sink attach
      t1 <= tccd_pkg::TCCD_RA;
      t2 <= tccd_pkg::TCCD_RD;
      cyc(12);
      t1 <= tccd_pkg::TCCD_OPEN;
      cyc(12);
      rchk("ra_ignored", `TCCD_OFF_STAT, 32'hF, 32'h3);
      t2 <= tccd_pkg::TCCD_OPEN;
      t1 <= tccd_pkg::TCCD_RD;
      cyc(12);
      apb(1'b1, `TCCD_OFF_CTRL, 32'hF0);
      // swap pull-down stands only until the sink-side decode drops the line
      cyc(3);
      chk("swap_pd", {role_swap_pulldown, vbus_source_en}, 32'h2);
      t1 <= tccd_pkg::TCCD_OPEN;
      apb(1'b1, `TCCD_OFF_CTRL, 32'hC1);
      cyc(4);
      chk("snk_pd", {trimmed_sink_pulldown, source_pullup_en}, 32'hC);
      for (int lv = 0; lv < 3; lv++)
      begin
         lvl <= 2'(lv);
         t1 <= tccd_pkg::TCCD_RP;
         cyc(12);
         rchk("snk_wait", `TCCD_OFF_STAT, 32'hF, 32'h6);
         vbus_present <= 1'b1;
         cyc(12);
         rchk("snk_att", `TCCD_OFF_STAT, 32'h300F, 32'((lv + 1) << 12) | 32'h7);
         t1 <= tccd_pkg::TCCD_OPEN;
         vbus_present <= 1'b0;
         cyc(12);
      end
      apb(1'b1, `TCCD_OFF_CTRL, 32'hD1);
      t1 <= tccd_pkg::TCCD_RP;
      vbus_present <= 1'b1;
      cyc(12);
      apb(1'b1, `TCCD_OFF_EVT, 32'h7);
      swp <= 2'h1;
      cyc(12);
      rchk("frs_evt", `TCCD_OFF_EVT, 32'h4, 32'h4);
      rchk("frs_src", `TCCD_OFF_STAT, 32'h10, 32'h10);
      swp <= 2'h0;
      t1 <= tccd_pkg::TCCD_OPEN;
      vbus_present <= 1'b0;
      // dual role: pull-up enable must keep alternating
      apb(1'b1, `TCCD_OFF_CTRL, 32'hC2);
      n = 0;
      prev = source_pullup_en;
      repeat (120)
      begin
         cyc(1);
         if (source_pullup_en !== prev)
            n++;
         prev = source_pullup_en;
      end
      chk("drp_toggle", 32'(n >= 4), 32'h1);
      complete_run();
   end
endmodule : typec_cc_attach_detect_tb
`default_nettype wire
